/* File: logic/sras_dev.sv */
`timescale 1ns/10ps
module sras_dev (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // serial link
  sras_spi_if.dev spi,
  // core side
  input wire logic core_por,
  input wire logic [sras_pkg::CORE_FLAGS_W-1:0] core_flags,
  input wire logic core_event,
  output logic event_req,
  output sras_pkg::sras_regs_t reg_bytes
);
  import sras_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic ss_m;
    logic ss_s;
    logic sck_m;
    logic sck_s;
    logic sck_d;
    logic mosi_m;
    logic mosi_s;
    logic [BIT_CNT_W-1:0] bit_cnt;
    logic addr_phase;
    logic wr;
    logic [IDX_W-1:0] ptr;
    sras_byte_t sr_in;
    sras_byte_t sr_out;
    logic miso;
    logic rst_done;
    logic ev;
    sras_regs_t regs;
  } sras_dev_s;

  sras_dev_s s;
  sras_dev_s next_s;

  // ****************************************
  // frame decode
  // ****************************************
  logic rise;
  logic fall;
  sras_byte_t status;
  sras_byte_t in_byte;
  logic [IDX_W-1:0] next_ptr;
  logic byte_end;

  // ****************************************
  // register read
  // ****************************************
  // index 0 has no storage of its own and reads back as the live status byte
  function automatic sras_byte_t read_reg(input sras_dev_s st, input sras_byte_t stat,
                                          input logic [IDX_W-1:0] idx);
    if (idx == STATUS_IDX) begin
      return stat;
    end
    return st.regs[idx];
  endfunction : read_reg

  // ****************************************
  // event level
  // ****************************************
  // quiet in core reset, then held high until the master acknowledges the reset
  function automatic logic event_level(input logic por, input logic done_flag,
                                       input logic ev_in);
    if (por) begin
      return 1'b0;
    end
    if (!done_flag) begin
      return 1'b1;
    end
    return ev_in;
  endfunction : event_level

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_s = s;
    rise = s.sck_s & ~s.sck_d;
    fall = ~s.sck_s & s.sck_d;
    status = {core_flags, s.rst_done};
    in_byte = {s.sr_in[BYTE_W-2:0], s.mosi_s};
    next_ptr = s.ptr + IDX_W'(1);
    // a byte ends on the rise of its eighth bit
    byte_end = rise & (s.bit_cnt == LAST_BIT);

    // two flops per pin and edges seen three clocks late, so sck half
    // periods shorter than one clock can slip past unseen
    next_s.ss_m = spi.ss_n;
    next_s.ss_s = s.ss_m;
    next_s.sck_m = spi.sck;
    next_s.sck_s = s.sck_m;
    next_s.sck_d = s.sck_s;
    next_s.mosi_m = spi.mosi;
    next_s.mosi_s = s.mosi_m;

    if (s.ss_s) begin
      // deselected: framing cleared, any partial byte dropped
      next_s.bit_cnt = '0;
      next_s.addr_phase = 1'b1;
      next_s.wr = 1'b0;
      next_s.sr_in = '0;
      // status preloaded so its msb is ready before the first rise
      next_s.miso = status[BYTE_W-1];
      next_s.sr_out = {status[BYTE_W-2:0], 1'b0};
    end else begin
      if (rise) begin
        next_s.sr_in = in_byte;
        next_s.bit_cnt = s.bit_cnt + BIT_CNT_W'(1);
        if (byte_end) begin
          if (s.addr_phase) begin
            next_s.addr_phase = 1'b0;
            next_s.wr = in_byte[WR_FLAG_BIT];
            next_s.ptr = in_byte[IDX_W-1:0];
            next_s.sr_out = read_reg(s, status, in_byte[IDX_W-1:0]);
          end else begin
            // mosi only matters when the write flag was set
            if (s.wr) begin
              if (s.ptr == STATUS_IDX) begin
                if (in_byte[RST_DONE_BIT]) begin
                  next_s.rst_done = 1'b1;
                end
              end else begin
                next_s.regs[s.ptr] = in_byte;
              end
            end
            next_s.ptr = next_ptr;
            // fetched from the old image, so a write never leaks into a read
            next_s.sr_out = read_reg(s, status, next_ptr);
          end
        end
      end
      if (fall) begin
        next_s.miso = s.sr_out[BYTE_W-1];
        next_s.sr_out = {s.sr_out[BYTE_W-2:0], 1'b0};
      end
    end

    // core reset overrides any master write in the same cycle
    if (core_por) begin
      next_s.rst_done = 1'b0;
      next_s.regs = {NUM_REGS{REG_RESET}};
    end
    next_s.ev = event_level(core_por, next_s.rst_done, core_event);
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
      s.ss_m <= 1'b1;
      s.ss_s <= 1'b1;
      s.regs <= {NUM_REGS{REG_RESET}};
    end else begin
      s <= next_s;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign spi.miso_o = s.miso;
  assign spi.miso_oe = ~s.ss_s;
  assign event_req = s.ev;

  // ****************************************
  // register image
  // ****************************************
  // slot 0 stands for the status byte, which has no storage here,
  // so its image stays at the reset value
  for (genvar gi = 0; gi < NUM_REGS; gi++) begin : g_image
    if (gi == STATUS_IDX) begin : g_status
      assign reg_bytes[gi] = REG_RESET;
    end else begin : g_data
      assign reg_bytes[gi] = s.regs[gi];
    end
  end
endmodule : sras_dev

/* File: logic/sras_pkg.sv */
package sras_pkg;
  // ****************************************
  // framing
  // ****************************************
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 7;
  localparam int BIT_CNT_W = 3;
  localparam logic [BIT_CNT_W-1:0] LAST_BIT = 3'h7;
  localparam int WR_FLAG_BIT = 7;
  // ****************************************
  // register storage
  // ****************************************
  localparam int NUM_REGS = 16;
  localparam int IDX_W = 4;
  localparam logic [IDX_W-1:0] STATUS_IDX = 4'h0;
  localparam int RST_DONE_BIT = 0;
  localparam int CORE_FLAGS_W = 7;
  localparam logic [BYTE_W-1:0] REG_RESET = 8'h00;
  // ****************************************
  // host side
  // ****************************************
  localparam int MAX_BURST = 4;
  localparam int LEN_W = 3;
  localparam int CLK_PERIOD_NS = 100;
  localparam int SCK_PERIOD_NS = 1600;
  localparam int SCK_HALF_CYC = SCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int DIV_W = 4;
  localparam logic [DIV_W-1:0] SCK_HALF_LAST = DIV_W'(SCK_HALF_CYC - 1);

  typedef logic [BYTE_W-1:0] sras_byte_t;
  typedef logic [NUM_REGS-1:0][BYTE_W-1:0] sras_regs_t;
  typedef logic [MAX_BURST-1:0][BYTE_W-1:0] sras_burst_t;
endpackage : sras_pkg

/* File: logic/sras_spi_if.sv */
`timescale 1ns/10ps
interface sras_spi_if;
  logic ss_n;
  logic sck;
  logic mosi;
  logic miso_o;
  logic miso_oe;
  wire miso;

  // shared line: a released miso shows its pull-up level, so only miso_oe
  // tells a driven line from a released one
  assign miso = miso_oe ? miso_o : 1'b1;

  modport dev (
    input ss_n,
    input sck,
    input mosi,
    output miso_o,
    output miso_oe
  );

  modport host (
    output ss_n,
    output sck,
    output mosi,
    input miso
  );
endinterface : sras_spi_if

/* File: logic/sras_host.sv */
`timescale 1ns/10ps
module sras_host (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // serial link
  sras_spi_if.host spi,
  // command
  input wire logic start,
  input wire logic cmd_write,
  input wire logic [sras_pkg::ADDR_W-1:0] cmd_addr,
  input wire logic [sras_pkg::LEN_W-1:0] cmd_len,
  input wire sras_pkg::sras_burst_t cmd_wdata,
  // answer
  output logic busy,
  output logic done,
  output sras_pkg::sras_byte_t status_byte,
  output sras_pkg::sras_burst_t rdata
);
  import sras_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_XFER, ST_HOLD} sras_host_e;

  typedef struct packed {
    sras_host_e st;
    logic [DIV_W-1:0] div;
    logic sck;
    logic ss_n;
    logic mosi;
    logic miso_m;
    logic miso_s;
    logic [BIT_CNT_W-1:0] bit_cnt;
    logic [LEN_W-1:0] byte_cnt;
    logic [LEN_W-1:0] len;
    sras_byte_t tx;
    sras_byte_t rx;
    sras_burst_t wdata;
    sras_byte_t status;
    sras_burst_t rdata;
    logic done;
  } sras_host_s;

  sras_host_s s;
  sras_host_s next_s;
  logic tick;
  sras_byte_t rx_byte;
  sras_byte_t nxt_tx;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_s = s;
    next_s.miso_m = spi.miso;
    next_s.miso_s = s.miso_m;
    next_s.done = 1'b0;
    tick = (s.div == SCK_HALF_LAST);
    next_s.div = tick ? '0 : s.div + DIV_W'(1);
    rx_byte = {s.rx[BYTE_W-2:0], s.miso_s};
    nxt_tx = s.wdata[s.byte_cnt[1:0]];

    unique case (s.st)
      ST_IDLE: begin
        next_s.div = '0;
        if (start && cmd_len != '0) begin
          next_s.st = ST_SETUP;
          next_s.ss_n = 1'b0;
          next_s.len = (cmd_len > LEN_W'(MAX_BURST)) ? LEN_W'(MAX_BURST) : cmd_len;
          next_s.wdata = cmd_wdata;
          next_s.tx = {cmd_write, cmd_addr};
          next_s.mosi = cmd_write;
          next_s.bit_cnt = '0;
          next_s.byte_cnt = '0;
        end
      end
      ST_SETUP: begin
        if (tick) begin
          next_s.st = ST_XFER;
        end
      end
      ST_XFER: begin
        if (tick && !s.sck) begin
          next_s.sck = 1'b1;
          next_s.rx = rx_byte;
        end else if (tick) begin
          next_s.sck = 1'b0;
          next_s.bit_cnt = s.bit_cnt + BIT_CNT_W'(1);
          if (s.bit_cnt == LAST_BIT) begin
            if (s.byte_cnt == '0) begin
              next_s.status = s.rx;
            end else begin
              next_s.rdata[s.byte_cnt[1:0] - 2'h1] = s.rx;
            end
            next_s.byte_cnt = s.byte_cnt + LEN_W'(1);
            next_s.tx = nxt_tx;
            next_s.mosi = nxt_tx[BYTE_W-1];
            if (s.byte_cnt == s.len) begin
              next_s.st = ST_HOLD;
            end
          end else begin
            next_s.tx = {s.tx[BYTE_W-2:0], 1'b0};
            next_s.mosi = s.tx[BYTE_W-2];
          end
        end
      end
      ST_HOLD: begin
        if (tick) begin
          next_s.st = ST_IDLE;
          next_s.ss_n = 1'b1;
          next_s.done = 1'b1;
        end
      end
    endcase
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
      s.st <= ST_IDLE;
      s.ss_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign spi.ss_n = s.ss_n;
  assign spi.sck = s.sck;
  assign spi.mosi = s.mosi;
  assign busy = (s.st != ST_IDLE);
  assign done = s.done;
  assign status_byte = s.status;
  assign rdata = s.rdata;
endmodule : sras_host

/* File: tb/sras_spi_assertions.sv */
`timescale 1ns/10ps
module sras_spi_assertions (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // serial link
  input wire logic ss_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso_o,
  input wire logic miso_oe
);
  // ****
  // helper: serial clock rises within a frame
  // ****
  logic sck_q;
  logic [5:0] rises;
  always_ff @(posedge clk) begin
    sck_q <= sck;
    if (rst || ss_n) begin
      rises <= 6'h00;
    end else if (sck && !sck_q) begin
      rises <= rises + 6'h01;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_oe_off; ss_n [*4] |-> !miso_oe; endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("miso driven while deselected");
  property p_oe_on; !ss_n [*4] |-> miso_oe; endproperty
  a_oe_on: assert property (p_oe_on)
    else $error("miso released while selected");
  property p_oe_cause; miso_oe |-> !$past(ss_n, 2); endproperty
  a_oe_cause: assert property (p_oe_cause)
    else $error("miso enabled without select");
  property p_miso_hold; sck [*4] |-> $stable(miso_o); endproperty
  a_miso_hold: assert property (p_miso_hold)
    else $error("miso moved while clock high");
  property p_setup; $fell(ss_n) |-> !sck [*7]; endproperty
  a_setup: assert property (p_setup)
    else $error("clock rose too soon after select");
  property p_idle; ss_n |-> !sck; endproperty
  a_idle: assert property (p_idle)
    else $error("clock active while deselected");
  property p_mosi; sck && $past(sck) |-> $stable(mosi); endproperty
  a_mosi: assert property (p_mosi)
    else $error("mosi moved while clock high");
  property p_half; $rose(sck) |-> sck [*8] ##1 !sck; endproperty
  a_half: assert property (p_half)
    else $error("clock high phase not eight cycles");
  property p_frame; $rose(ss_n) |-> rises[2:0] == 3'h0 && rises >= 6'h10; endproperty
  a_frame: assert property (p_frame)
    else $error("frame not whole bytes");
  c_open: cover property ($fell(ss_n));
  c_drive: cover property (miso_oe && sck);
  c_close: cover property ($rose(ss_n));
endmodule : sras_spi_assertions

/* File: tb/spi_register_access_reset_status_test.sv */
`timescale 1ns/10ps
module spi_register_access_reset_status_test;
  import sras_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic core_por = 1'b1;
  logic [CORE_FLAGS_W-1:0] core_flags = 7'h5a;
  logic core_event = 1'b0;
  logic event_req;
  sras_regs_t reg_bytes;
  logic start = 1'b0;
  logic cmd_write = 1'b0;
  logic [ADDR_W-1:0] cmd_addr = 7'h00;
  logic [LEN_W-1:0] cmd_len = 3'h1;
  sras_burst_t cmd_wdata = '0;
  logic busy;
  logic done;
  sras_byte_t status_byte;
  sras_burst_t rdata;
  int fail_count = 0;
  int n_compared = 0;
  int cyc = 0;
  sras_spi_if sif();
  sras_dev i_sras_dev (.clk(clk), .rst(rst), .spi(sif), .core_por(core_por),
    .core_flags(core_flags), .core_event(core_event), .event_req(event_req),
    .reg_bytes(reg_bytes));
  sras_host i_sras_host (.clk(clk), .rst(rst), .spi(sif), .start(start),
    .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_len(cmd_len), .cmd_wdata(cmd_wdata),
    .busy(busy), .done(done), .status_byte(status_byte), .rdata(rdata));
  sras_spi_assertions i_sras_spi_assertions (.clk(clk), .rst(rst), .ss_n(sif.ss_n),
    .sck(sif.sck), .mosi(sif.mosi), .miso_o(sif.miso_o), .miso_oe(sif.miso_oe));
  always #50 clk = ~clk;
  // ****
  // shared tasks
  // ****
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim
  // xfer gives up on a hung access after 3000 clocks; the cycle ceiling ends a run that hangs elsewhere
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      fail_count = fail_count + 1;
      end_sim();
    end
  end
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [6:0] a, input logic [2:0] n,
                      input sras_burst_t d);
    @(posedge clk);
    start <= 1'b1;
    cmd_write <= w;
    cmd_addr <= a;
    cmd_len <= n;
    cmd_wdata <= d;
    @(posedge clk);
    start <= 1'b0;
    @(posedge clk);
    chk(busy, 1'b1);
    repeat (3000) if (done !== 1'b1) @(posedge clk);
    chk(done, 1'b1);
    chk(busy, 1'b0);
    // the device sees the select rise two clocks after the host drops it
    repeat (2) @(posedge clk);
  endtask : xfer
  // ****
  // scenarios
  // ****
  task automatic t_por();
    xfer(1'b0, 7'h00, 3'h1, '0);
    chk(status_byte, {7'h5a, 1'b0});
    chk(rdata[0], {7'h5a, 1'b0});
    chk(event_req, 1'b0);
    chk(sif.miso_oe, 1'b0);
    chk(sif.miso, 1'b1);
  endtask : t_por
  task automatic t_release();
    core_por <= 1'b0;
    repeat (4) @(posedge clk);
    chk(event_req, 1'b1);
    xfer(1'b0, 7'h00, 3'h1, '0);
    chk(status_byte[0], 1'b0);
    xfer(1'b1, 7'h00, 3'h1, 32'h1);
    xfer(1'b0, 7'h00, 3'h1, '0);
    chk(status_byte, {7'h5a, 1'b1});
    chk(event_req, 1'b0);
    core_event <= 1'b1;
    repeat (4) @(posedge clk);
    chk(event_req, 1'b1);
  endtask : t_release
  task automatic t_burst();
    xfer(1'b1, 7'h75, 3'h4, 32'hd4c3b2a1);
    chk(rdata, 32'h0);
    chk(reg_bytes[8:5], 32'hd4c3b2a1);
    xfer(1'b1, 7'h05, 3'h2, 32'hffff2211);
    chk(rdata[1:0], 16'hb2a1);
    chk(reg_bytes[8:5], 32'hd4c32211);
    xfer(1'b0, 7'h05, 3'h4, 32'hffffffff);
    chk(rdata, 32'hd4c32211);
    chk(reg_bytes[8:5], 32'hd4c32211);
  endtask : t_burst
  task automatic t_wrap();
    xfer(1'b1, 7'h0f, 3'h2, 32'h0099);
    chk(reg_bytes[15], 8'h99);
    chk(status_byte[0], 1'b1);
  endtask : t_wrap
  task automatic t_core_reset();
    core_por <= 1'b1;
    repeat (4) @(posedge clk);
    chk(reg_bytes, '0);
    core_por <= 1'b0;
    repeat (4) @(posedge clk);
    chk(event_req, 1'b1);
    xfer(1'b0, 7'h00, 3'h1, '0);
    chk(status_byte[0], 1'b0);
    xfer(1'b1, 7'h05, 3'h4, 32'hd4c32211);
    chk(rdata, 32'h0);
    chk(reg_bytes[8:5], 32'hd4c32211);
  endtask : t_core_reset
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_por();
    t_release();
    t_burst();
    t_wrap();
    t_core_reset();
    end_sim();
  end
endmodule : spi_register_access_reset_status_test
